// ==== src/mcsp_cfg.svh ====
// timing and framing constants for the melody serial control port
`ifndef MCSP_CFG_SVH
`define MCSP_CFG_SVH
`define MCSP_INDEX_BITS      8
`define MCSP_DATA_BITS       16
`define MCSP_FULL_BITS       24
`define MCSP_SCORE_INDEX     8'h00
`define MCSP_CLK_PERIOD_PS   5000
`define MCSP_SCLK_HALF_NS    200
`define MCSP_SCLK_HALF_CYC   ((`MCSP_SCLK_HALF_NS * 1000 + `MCSP_CLK_PERIOD_PS - 1) / `MCSP_CLK_PERIOD_PS)
`define MCSP_SYNC_GAP_NS     100
`define MCSP_SYNC_GAP_CYC    ((`MCSP_SYNC_GAP_NS * 1000 + `MCSP_CLK_PERIOD_PS - 1) / `MCSP_CLK_PERIOD_PS)
`endif

// ==== src/mcsp_pkg.sv ====
// state type of the host end of the melody serial control port
package mcsp_pkg;
  typedef enum {
    MCSP_H_IDLE,
    MCSP_H_LOW,
    MCSP_H_HIGH,
    MCSP_H_GAP,
    MCSP_H_STROBE
  } mcsp_host_state_t;
endpackage : mcsp_pkg

// ==== src/mcsp_link_if.sv ====
// three-wire link between host and melody device
`timescale 1ns/1ps
interface mcsp_link_if;
  logic serial_clk;
  logic frame_strobe;
  logic serial_data_in;
  modport host (output serial_clk, output frame_strobe, output serial_data_in);
  modport device (input serial_clk, input frame_strobe, input serial_data_in);
endinterface : mcsp_link_if

// ==== src/mcsp_device.sv ====
// device end: samples the serial link and delivers index/data words
//
// Function
// [RQ1] sample data on each serial clock rise
// [RQ2] strobe rise ends a transfer, acts
// [RQ3] full transfer uses last 24 bits
// [RQ4] sixteen-bit transfer goes to score index
// [RQ5] index and data contiguous or paused
// [RQ6] data may come as two bytes
// [RQ7] host keeps clock away from strobe
// [RQ8] host paces score loads against empty; mcsp_host does not, and leaves it to the request source
// [RQ9] strobe high time is unconstrained
// [RQ10] host never overfills score fifo; mcsp_host does not check, and leaves it to the request source
// [RQ11] msb first, index before data
`timescale 1ns/1ps
`include "mcsp_cfg.svh"
module mcsp_device
  import mcsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  mcsp_link_if.device      link,
  output logic             wr_valid,
  output logic [7:0]       wr_index,
  output logic [15:0]      wr_data,
  output logic             wr_short
);
  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers, one per pin, third stage for edge detection
  localparam int         PIN_COUNT = 3;
  // strobe idles high; resetting its stages low would fake a frame end
  localparam logic [2:0] PIN_IDLE  = 3'h2;

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_last;

  assign pin_raw = {link.serial_data_in, link.frame_strobe, link.serial_clk};

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
    logic [2:0] stage;
    logic [2:0] next_stage;

    always_comb begin
      next_stage = {stage[1:0], pin_raw[p]};
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        stage <= {3{PIN_IDLE[p]}};
      end else begin
        stage <= next_stage;
      end
    end

    // only the second stage reads the first
    assign pin_sync[p] = stage[1];
    assign pin_last[p] = stage[2];
  end

  logic sclk_rise;
  logic sync_rise;
  logic din;
  // data delayed alike with the clock, so setup at the pins is kept
  assign sclk_rise = pin_sync[0] & ~pin_last[0];
  assign sync_rise = pin_sync[1] & ~pin_last[1];
  assign din       = pin_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // shifter and bit counter
  logic [23:0] shreg;
  logic [4:0]  bit_cnt;
  logic [23:0] shifted;
  logic [4:0]  counted;
  logic [23:0] next_shreg;
  logic [4:0]  next_bit_cnt;

  always_comb begin
    shifted = shreg;
    counted = bit_cnt;
    if (sclk_rise) begin
      // clock bits arriving between pieces keep shifting in, so a pause is harmless
      shifted = {shreg[22:0], din}; // RQ1 RQ11 RQ5 RQ6
      // saturating count: a long frame keeps only its newest bits
      if (bit_cnt != 5'(`MCSP_FULL_BITS)) begin
        counted = 5'(bit_cnt + 5'h01);
      end
    end
    next_shreg   = shifted;
    // a clock rise in the strobe cycle still counts for the ending frame
    next_bit_cnt = sync_rise ? 5'h00 : counted; // RQ2 RQ9
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shreg   <= 24'h000000;
      bit_cnt <= 5'h00;
    end else begin
      shreg   <= next_shreg;
      bit_cnt <= next_bit_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decode and output words
  logic        frame_short;
  logic        frame_full;
  logic        out_valid;
  logic [7:0]  out_index;
  logic [15:0] out_data;
  logic        out_short;
  logic        next_out_valid;
  logic [7:0]  next_out_index;
  logic [15:0] next_out_data;
  logic        next_out_short;

  // lengths of 17 to 23 bits match neither form and are dropped silently
  assign frame_short = sync_rise & (counted == 5'(`MCSP_DATA_BITS));
  assign frame_full  = sync_rise & (counted >= 5'(`MCSP_FULL_BITS));

  always_comb begin
    next_out_valid = 1'b0;
    next_out_index = out_index;
    next_out_data  = out_data;
    next_out_short = out_short;
    if (frame_short) begin // RQ2
      next_out_valid = 1'b1;
      next_out_index = `MCSP_SCORE_INDEX; // RQ4
      next_out_data  = shifted[15:0];
      next_out_short = 1'b1;
    end else if (frame_full) begin // RQ2
      next_out_valid = 1'b1;
      next_out_index = shifted[23:16]; // RQ3 RQ11
      next_out_data  = shifted[15:0];
      next_out_short = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_index <= 8'h00;
      out_data  <= 16'h0000;
      out_short <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_index <= next_out_index;
      out_data  <= next_out_data;
      out_short <= next_out_short;
    end
  end

  // outputs straight from the word registers
  assign wr_valid = out_valid;
  assign wr_index = out_index;
  assign wr_data  = out_data;
  assign wr_short = out_short;
endmodule : mcsp_device

// ==== src/mcsp_host.sv ====
// host end: serialises index/data words onto the three-wire link
`timescale 1ns/1ps
`include "mcsp_cfg.svh"
module mcsp_host
  import mcsp_pkg::*;
#(
  parameter int HALF_CYC = `MCSP_SCLK_HALF_CYC,
  parameter int GAP_CYC  = `MCSP_SYNC_GAP_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  mcsp_link_if.host        link,
  input  wire logic        req_valid,
  input  wire logic        req_short,
  input  wire logic [7:0]  req_index,
  input  wire logic [15:0] req_data,
  output logic             req_ready
);
  // tick counters are eight bits wide and count down to one
  if (HALF_CYC < 1 || HALF_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_bad_timing
    $error("mcsp_host: timing parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  mcsp_host_state_t state;
  mcsp_host_state_t next_state;
  logic [23:0] shreg;
  logic [4:0]  bits_left;
  logic [7:0]  tick;
  logic        sclk;
  logic        strobe;
  logic        sdo;
  logic        ready;
  logic [23:0] next_shreg;
  logic [4:0]  next_bits_left;
  logic [7:0]  next_tick;
  logic        next_sclk;
  logic        next_strobe;
  logic        next_sdo;
  logic        next_ready;

  always_comb begin
    next_state     = state;
    next_shreg     = shreg;
    next_bits_left = bits_left;
    next_tick      = tick;
    next_sclk      = sclk;
    next_strobe    = strobe;
    next_sdo       = sdo;
    next_ready     = 1'b0;
    case (state)
      MCSP_H_IDLE: begin
        next_ready = ~req_valid;
        if (req_valid && ready) begin
          // strobe low opens the frame; msb first, index leading in full frames, data alone in short ones
          next_strobe = 1'b0;
          next_sclk   = 1'b0;
          if (req_short) begin
            next_shreg     = {req_data, 8'h00}; // RQ4
            next_bits_left = 5'(`MCSP_DATA_BITS);
          end else begin
            next_shreg     = {req_index, req_data}; // RQ11 RQ5
            next_bits_left = 5'(`MCSP_FULL_BITS);
          end
          next_tick  = 8'(HALF_CYC);
          next_state = MCSP_H_LOW;
        end
      end
      MCSP_H_LOW: begin
        next_sdo = shreg[23];
        if (tick == 8'h01) begin
          next_sclk  = 1'b1;
          next_tick  = 8'(HALF_CYC);
          next_shreg = {shreg[22:0], 1'b0};
          next_bits_left = 5'(bits_left - 5'h01);
          next_state = MCSP_H_HIGH;
        end else begin
          next_tick = 8'(tick - 8'h01);
        end
      end
      MCSP_H_HIGH: begin
        if (tick == 8'h01) begin
          next_sclk = 1'b0;
          next_tick = 8'(HALF_CYC);
          next_state = (bits_left == 5'h00) ? MCSP_H_GAP : MCSP_H_LOW;
        end else begin
          next_tick = 8'(tick - 8'h01);
        end
      end
      MCSP_H_GAP: begin
        // clock held low a full half period before the strobe rises
        if (tick == 8'h01) begin
          next_strobe = 1'b1; // RQ7 RQ2
          next_tick   = 8'(GAP_CYC);
          next_state  = MCSP_H_STROBE;
        end else begin
          next_tick = 8'(tick - 8'h01);
        end
      end
      MCSP_H_STROBE: begin
        if (tick == 8'h01) begin
          next_ready = 1'b1;
          next_state = MCSP_H_IDLE; // RQ9
        end else begin
          next_tick = 8'(tick - 8'h01);
        end
      end
      default: begin
        next_state = MCSP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= MCSP_H_IDLE;
      shreg     <= 24'h000000;
      bits_left <= 5'h00;
      tick      <= 8'h00;
      sclk      <= 1'b0;
      strobe    <= 1'b1;
      sdo       <= 1'b0;
      ready     <= 1'b0;
    end else begin
      state     <= next_state;
      shreg     <= next_shreg;
      bits_left <= next_bits_left;
      tick      <= next_tick;
      sclk      <= next_sclk;
      strobe    <= next_strobe;
      sdo       <= next_sdo;
      ready     <= next_ready;
    end
  end

  // pacing against fifo level is the request source's duty
  assign req_ready           = ready; // RQ8 RQ10
  assign link.serial_clk     = sclk;
  assign link.frame_strobe   = strobe;
  assign link.serial_data_in = sdo;
endmodule : mcsp_host

// ==== sim/mcsp_asserts.sv ====
// link and answer checks for the melody serial control port
`timescale 1ns/1ps
module mcsp_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic frame_strobe,
  input wire logic serial_data_in,
  input wire logic wr_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // widths assume the bench's half period of 4 and gap of 2
  property p_data_hold; serial_clk |-> $stable(serial_data_in); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved with clock high");
  property p_high_width; $rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk; endproperty
  a_high_width: assert property (p_high_width) else $error("clock high width wrong");
  property p_low_width; $fell(serial_clk) |-> !serial_clk [*4]; endproperty
  a_low_width: assert property (p_low_width) else $error("clock low width short");
  property p_quiet; frame_strobe |-> !serial_clk; endproperty
  a_quiet: assert property (p_quiet) else $error("clock moved with strobe high");
  property p_rise_gap; $rose(frame_strobe) |-> !$past(serial_clk, 3); endproperty
  a_rise_gap: assert property (p_rise_gap) else $error("clock too near strobe");
  property p_high_min; $rose(frame_strobe) |-> frame_strobe [*2]; endproperty
  a_high_min: assert property (p_high_min) else $error("strobe high too short");
  property p_valid_soon; $rose(frame_strobe) |-> ##[1:6] wr_valid; endproperty
  a_valid_soon: assert property (p_valid_soon) else $error("no word after strobe");
  property p_valid_pulse; wr_valid |=> !wr_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("word pulse too long");
  property p_valid_cause; wr_valid |-> $past(frame_strobe, 2); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("word without strobe");
  c_frame: cover property ($rose(frame_strobe));
  c_word: cover property (wr_valid);
  c_bit: cover property ($rose(serial_clk) && serial_data_in);
endmodule : mcsp_asserts

// ==== sim/melody_chip_serial_control_port_bench.sv ====
// bench for both ends of the melody serial control port
`timescale 1ns/1ps
module melody_chip_serial_control_port_bench;
  import mcsp_pkg::*;
  logic        clk, rst, rv, rs, rr, va, sa, vb, sb;
  logic [7:0]  ri, ia, ib;
  logic [15:0] rd, da, db;
  logic [23:0] sh;
  int          bad_count, comparisons, cnt_b, c0;
  mcsp_link_if link_a ();
  mcsp_link_if link_b ();
  mcsp_host #(.HALF_CYC(4), .GAP_CYC(2)) u_mcsp_host (.clk(clk), .rst(rst), .link(link_a),
    .req_valid(rv), .req_short(rs), .req_index(ri), .req_data(rd), .req_ready(rr));
  mcsp_device u_mcsp_device (.clk(clk), .rst(rst), .link(link_a), .wr_valid(va),
    .wr_index(ia), .wr_data(da), .wr_short(sa));
  // second device faces the bench driver, which bends the framing
  mcsp_device u_mcsp_device_2 (.clk(clk), .rst(rst), .link(link_b), .wr_valid(vb),
    .wr_index(ib), .wr_data(db), .wr_short(sb));
  mcsp_asserts u_mcsp_asserts (.clk(clk), .rst(rst), .serial_clk(link_a.serial_clk),
    .frame_strobe(link_a.frame_strobe), .serial_data_in(link_a.serial_data_in), .wr_valid(va));
  always @(posedge link_a.serial_clk) sh <= {sh[22:0], link_a.serial_data_in};
  always @(posedge clk) if (vb === 1'b1) cnt_b++;
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [24:0] got, input logic [24:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic word(input logic b, input logic [24:0] exp);
    int n;
    n = 0;
    // the valid pulse stands from one rising edge to the next
    while (((b ? vb : va) !== 1'b1) && n < 800) begin
      @(negedge clk);
      n++;
    end
    cmp((n < 800) ? (b ? {sb, ib, db} : {sa, ia, da}) : 25'bx, exp);
  endtask : word
  task automatic send(input logic s, input logic [7:0] i, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    {rv, rs, ri, rd} = {1'b1, s, i, d};
    // ready seen at a falling edge stands at the rising edge that takes the word
    while (rr !== 1'b1 && n < 800) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    rv = 0;
  endtask : send
  // link clock stands still outside these bursts
  task automatic bits(input int n, input logic [31:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.serial_data_in = v[i];
      #24 link_b.serial_clk = 1;
      #24 link_b.serial_clk = 0;
    end
    link_b.serial_data_in = ~v[0];
  endtask : bits
  task automatic frame(input int n, input logic [31:0] v);
    link_b.frame_strobe = 0;
    #24 bits(n, v);
    #24 link_b.frame_strobe = 1;
  endtask : frame
  initial begin
    {rst, rv, rs, ri, rd} = {1'b1, 26'h0};
    {link_b.serial_clk, link_b.frame_strobe, link_b.serial_data_in} = 3'b010;
    repeat (12) @(negedge clk);
    rst = 0;
    send(1'b0, 8'h5A, 16'hC3A5);
    word(0, {1'b0, 8'h5A, 16'hC3A5});
    cmp({1'b0, sh}, {1'b0, 24'h5AC3A5});
    send(1'b1, 8'h77, 16'h8001);
    word(0, {1'b1, 8'h00, 16'h8001});
    cmp({9'h0, sh[15:0]}, {9'h0, 16'h8001});
    cmp({24'h0, link_a.frame_strobe}, 25'h1);
    $display("host frames done");
    frame(24, 32'hA1B2C3);
    word(1, {1'b0, 8'hA1, 16'hB2C3});
    frame(16, 32'h1234);
    word(1, {1'b1, 8'h00, 16'h1234});
    frame(32, 32'hEE96F00F);
    word(1, {1'b0, 8'h96, 16'hF00F});
    link_b.frame_strobe = 0;
    #24 bits(8, 32'h3C);
    #600 bits(8, 32'h81);
    #900 bits(8, 32'h7E);
    #24 link_b.frame_strobe = 1;
    word(1, {1'b0, 8'h3C, 16'h817E});
    #5000 c0 = cnt_b;
    frame(20, 32'hFFFFF);
    repeat (60) @(negedge clk);
    cmp(25'(cnt_b), 25'(c0));
    frame(16, 32'h00FF);
    word(1, {1'b1, 8'h00, 16'h00FF});
    $display("driver frames done");
    complete_run();
  end
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule : melody_chip_serial_control_port_bench
